/* File: common/axt_pkg.sv */
package axt_pkg;
  localparam int NUM_TIMED = 4;
  localparam int NUM_BLOCKABLE = 3;
  localparam int NUM_PASS = 2;
  localparam int DLY_W = 20;
  localparam int FUNC_W = 3;
  // time base
  localparam int CLK_FREQ_MHZ = 250;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * CLK_FREQ_MHZ * 1000;
  // delay range in milliseconds
  localparam int DELAY_MAX_S = 600;
  localparam logic [DLY_W-1:0] DELAY_MAX_MS = DLY_W'(DELAY_MAX_S * 1000);
  localparam logic [DLY_W-1:0] DELAY_RESET = 20'h00000;
  // channel functions
  localparam logic [FUNC_W-1:0] FN_TRIP = 3'h0;
  localparam logic [FUNC_W-1:0] FN_ALARM = 3'h1;
  localparam logic [FUNC_W-1:0] FN_TRIP_INRUSH = 3'h2;
  localparam logic [FUNC_W-1:0] FN_TRIP_LATCH = 3'h3;
  localparam logic [FUNC_W-1:0] FN_LOAD_SHED = 3'h4;
  localparam logic [FUNC_W-1:0] FN_RECLOSE_HIGH = 3'h5;
  localparam logic [FUNC_W-1:0] FN_RECLOSE_LOW = 3'h6;
  localparam logic [11:0] FUNC_RESET = 12'h000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_DELAY0 = 8'h20;
  localparam logic [7:0] OFS_DELAY1 = 8'h24;
  localparam logic [7:0] OFS_DELAY2 = 8'h28;
  localparam logic [7:0] OFS_DELAY3 = 8'h2c;
  // field positions
  localparam int CTRL_SIG_RESET_BIT = 0;
  localparam int ST_RAW_LSB = 0;
  localparam int ST_EXP_LSB = 4;
  localparam int ST_PASS_LSB = 8;
  localparam int ST_LATCH_BIT = 10;
  localparam int IRQ_EXP_LSB = 0;
  localparam int IRQ_LATCH_BIT = 4;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    AXT_W_IDLE = 2'b01,
    AXT_W_RESP = 2'b10
  } axt_wstate_e;
endpackage

/* File: core/axt_sync.sv */
`timescale 1ns/1ps
module axt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: core/axt_delay.sv */
`timescale 1ns/1ps
module axt_delay
  import axt_pkg::*;
#(
  parameter int DW = DLY_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic [DW-1:0] delay_in,
  output logic expired_out
);
  logic [DW-1:0] count_reg;
  logic [DW-1:0] count_next;
  logic reached;

  assign reached = count_reg >= delay_in;
  // a dropped start clears the count so the next start runs the full delay
  assign count_next = !start_in ? '0 :
                      (tick_in && !reached) ? count_reg + 1'b1 : count_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= '0;
      expired_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_out <= start_in && reached;
    end
  end
endmodule

/* File: core/axt_aux_timers.sv */
`timescale 1ns/1ps
module axt_aux_timers
  import axt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // binary inputs from pins
  input wire logic [NUM_TIMED-1:0] timed_input_in,
  input wire logic [NUM_BLOCKABLE-1:0] channel_block_input_in,
  input wire logic [NUM_PASS-1:0] passthrough_input_in,
  input wire logic inrush_block_in,
  input wire logic signal_reset_in,
  // outputs to relays and leds
  output logic prot_trip_out,
  output logic trip_pulse_out,
  output logic recorder_trigger_out,
  output logic trip_led_out,
  output logic trip_flag_out,
  output logic alarm_out,
  output logic alarm_led_out,
  output logic breaker_open_command_out,
  output logic breaker_close_command_out,
  output logic [NUM_TIMED-1:0] aux_state_out,
  output logic [NUM_TIMED-1:0] channel_delay_expired_out,
  output logic [NUM_PASS-1:0] passthrough_out,
  output logic irq_out
);
  localparam int SYNC_W = NUM_TIMED + NUM_BLOCKABLE + NUM_PASS + 2;
  localparam int TDIV_W = $clog2(TICK_DIV + 1);
  localparam logic [TDIV_W-1:0] TDIV_LAST = TDIV_W'(TICK_DIV - 1);

  // synchronised pins
  logic [SYNC_W-1:0] pins_sync;
  logic [NUM_TIMED-1:0] aux_in;
  logic [NUM_BLOCKABLE-1:0] block_in;
  logic [NUM_PASS-1:0] pass_in;
  logic inrush_in;
  logic pin_sig_reset;

  // time base
  logic [TDIV_W-1:0] tdiv_reg;
  logic tick;

  // register file
  logic [FUNC_W*NUM_TIMED-1:0] func_reg;
  logic [DLY_W-1:0] delay_reg [NUM_TIMED];
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic sw_sig_reset;

  // channel logic
  logic [NUM_TIMED-1:0] start;
  logic [NUM_TIMED-1:0] expired;
  logic [NUM_TIMED-1:0] expired_prev_reg;
  logic [NUM_TIMED-1:0] is_trip, is_latch, is_alarm, is_shed, is_close;
  logic [NUM_TIMED-1:0] exp_rise;
  logic latch_reg, latch_next, sig_reset, trip_now, trip_prev_reg;
  logic [IRQ_W-1:0] irq_events;

  // bus
  axt_wstate_e wstate_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_take, w_take, do_write;
  logic [31:0] wmask;
  logic wr_ctrl, wr_func, wr_irq_stat, wr_irq_mask;
  logic [NUM_TIMED-1:0] wr_delay;
  logic wr_hit, ar_take;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] status_word;

  axt_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in({signal_reset_in, inrush_block_in, passthrough_input_in,
               channel_block_input_in, timed_input_in}),
    .sync_out(pins_sync)
  );

  assign aux_in = pins_sync[NUM_TIMED-1:0];
  assign block_in = pins_sync[NUM_TIMED +: NUM_BLOCKABLE];
  assign pass_in = pins_sync[NUM_TIMED+NUM_BLOCKABLE +: NUM_PASS];
  assign inrush_in = pins_sync[SYNC_W-2];
  assign pin_sig_reset = pins_sync[SYNC_W-1];

  // millisecond tick divider
  assign tick = tdiv_reg == TDIV_LAST;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tdiv_reg <= '0;
    end else begin
      tdiv_reg <= tick ? '0 : tdiv_reg + 1'b1;
    end
  end

  // per-channel start, function decode and timer
  genvar g;
  generate
    for (g = 0; g < NUM_TIMED; g++) begin : g_chan
      logic [FUNC_W-1:0] fn;
      logic raw_start;
      logic blocked;
      assign fn = func_reg[g*FUNC_W +: FUNC_W];
      // low-level reclose starts on a de-energized input
      assign raw_start = (fn == FN_RECLOSE_LOW) ? !aux_in[g] :
                         aux_in[g];
      if (g < NUM_BLOCKABLE) begin : g_blk
        assign blocked = block_in[g];
      end else begin : g_noblk
        assign blocked = 1'b0;
      end
      assign start[g] = raw_start && !blocked;
      assign is_trip[g] = (fn == FN_TRIP) || (fn == FN_TRIP_LATCH) ||
                          ((fn == FN_TRIP_INRUSH) && !inrush_in);
      assign is_latch[g] = fn == FN_TRIP_LATCH;
      assign is_alarm[g] = fn == FN_ALARM;
      assign is_shed[g] = fn == FN_LOAD_SHED;
      assign is_close[g] = (fn == FN_RECLOSE_HIGH) || (fn == FN_RECLOSE_LOW);

      axt_delay #(
        .DW(DLY_W)
      ) u_delay (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .start_in(start[g]),
        .delay_in(delay_reg[g]),
        .expired_out(expired[g])
      );
    end
  endgenerate

  // latched trip holds until signalling reset; a new expiry wins over reset
  assign sig_reset = pin_sig_reset || sw_sig_reset;
  assign latch_next = (|(expired & is_latch)) ? 1'b1 :
                      sig_reset ? 1'b0 : latch_reg;
  assign trip_now = (|(expired & is_trip)) || latch_reg;
  assign exp_rise = expired & ~expired_prev_reg;
  assign irq_events = {latch_next & ~latch_reg, exp_rise};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_reg <= 1'b0;
      expired_prev_reg <= '0;
      trip_prev_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      expired_prev_reg <= expired;
      trip_prev_reg <= trip_now;
    end
  end

  // output drivers, all registered
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prot_trip_out <= 1'b0;
      trip_pulse_out <= 1'b0;
      recorder_trigger_out <= 1'b0;
      trip_led_out <= 1'b0;
      trip_flag_out <= 1'b0;
      alarm_out <= 1'b0;
      alarm_led_out <= 1'b0;
      breaker_open_command_out <= 1'b0;
      breaker_close_command_out <= 1'b0;
      aux_state_out <= '0;
      channel_delay_expired_out <= '0;
      passthrough_out <= '0;
    end else begin
      prot_trip_out <= trip_now;
      trip_pulse_out <= trip_now && !trip_prev_reg;
      recorder_trigger_out <= trip_now && !trip_prev_reg;
      trip_led_out <= trip_now;
      trip_flag_out <= trip_now;
      alarm_out <= |(expired & is_alarm);
      alarm_led_out <= |(expired & is_alarm);
      breaker_open_command_out <= |(expired & is_shed);
      breaker_close_command_out <= |(expired & is_close);
      aux_state_out <= aux_in;
      channel_delay_expired_out <= expired;
      passthrough_out <= pass_in;
    end
  end

  // interrupt: sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat_reg <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_stat_reg <= irq_events |
        (irq_stat_reg & ~(wr_irq_stat ? wdata_reg[IRQ_W-1:0] : '0));
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // axi4-lite write path; address and data accepted in either order
  assign s_axi_awready_out = !aw_have_reg && (wstate_reg == AXT_W_IDLE);
  assign s_axi_wready_out = !w_have_reg && (wstate_reg == AXT_W_IDLE);
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign do_write = aw_have_reg && w_have_reg;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_ctrl = do_write && (awaddr_reg == OFS_CTRL);
  assign wr_func = do_write && (awaddr_reg == OFS_FUNC);
  assign wr_irq_stat = do_write && (awaddr_reg == OFS_IRQ_STAT) &&
                       wstrb_reg[0];
  assign wr_irq_mask = do_write && (awaddr_reg == OFS_IRQ_MASK);
  assign wr_delay[0] = do_write && (awaddr_reg == OFS_DELAY0);
  assign wr_delay[1] = do_write && (awaddr_reg == OFS_DELAY1);
  assign wr_delay[2] = do_write && (awaddr_reg == OFS_DELAY2);
  assign wr_delay[3] = do_write && (awaddr_reg == OFS_DELAY3);
  assign wr_hit = wr_ctrl || wr_func || (do_write &&
                  ((awaddr_reg == OFS_IRQ_STAT) ||
                   (awaddr_reg == OFS_STATUS))) ||
                  wr_irq_mask || (|wr_delay);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wstate_reg <= AXT_W_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      case (wstate_reg)
        AXT_W_IDLE: begin
          if (aw_take) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= {s_axi_awaddr_in[7:2], 2'b00};
          end
          if (w_take) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_in;
            wstrb_reg <= s_axi_wstrb_in;
          end
          if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wstate_reg <= AXT_W_RESP;
          end
        end
        AXT_W_RESP: begin
          if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            wstate_reg <= AXT_W_IDLE;
          end
        end
        default: wstate_reg <= AXT_W_IDLE;
      endcase
    end
  end

  // control registers; delays saturate at the top of the range
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      func_reg <= FUNC_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      sw_sig_reset <= 1'b0;
      for (int i = 0; i < NUM_TIMED; i++) begin
        delay_reg[i] <= DELAY_RESET;
      end
    end else begin
      sw_sig_reset <= wr_ctrl && wstrb_reg[0] &&
                      wdata_reg[CTRL_SIG_RESET_BIT];
      if (wr_func) begin
        func_reg <= (func_reg & ~wmask[11:0]) |
                    (wdata_reg[11:0] & wmask[11:0]);
      end
      if (wr_irq_mask && wstrb_reg[0]) begin
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      end
      for (int i = 0; i < NUM_TIMED; i++) begin
        if (wr_delay[i]) begin
          delay_reg[i] <= dly_clamp(
            (delay_reg[i] & ~wmask[DLY_W-1:0]) |
            (wdata_reg[DLY_W-1:0] & wmask[DLY_W-1:0]));
        end
      end
    end
  end

  function automatic logic [DLY_W-1:0] dly_clamp(input logic [DLY_W-1:0] v);
    dly_clamp = (v > DELAY_MAX_MS) ? DELAY_MAX_MS : v;
  endfunction

  // axi4-lite read path
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign status_word = {21'h000000, latch_reg, pass_in, expired, aux_in};
  assign rd_hit = (s_axi_araddr_in[7:2] == OFS_CTRL[7:2]) ||
                  (s_axi_araddr_in[7:2] == OFS_FUNC[7:2]) ||
                  (s_axi_araddr_in[7:2] == OFS_STATUS[7:2]) ||
                  (s_axi_araddr_in[7:2] == OFS_IRQ_STAT[7:2]) ||
                  (s_axi_araddr_in[7:2] == OFS_IRQ_MASK[7:2]) ||
                  (s_axi_araddr_in[7:4] == OFS_DELAY0[7:4]);
  assign rd_data =
    (s_axi_araddr_in[7:2] == OFS_FUNC[7:2]) ? {20'h00000, func_reg} :
    (s_axi_araddr_in[7:2] == OFS_STATUS[7:2]) ? status_word :
    (s_axi_araddr_in[7:2] == OFS_IRQ_STAT[7:2]) ? {27'h0000000, irq_stat_reg} :
    (s_axi_araddr_in[7:2] == OFS_IRQ_MASK[7:2]) ? {27'h0000000, irq_mask_reg} :
    (s_axi_araddr_in[7:4] == OFS_DELAY0[7:4]) ?
      {12'h000, delay_reg[s_axi_araddr_in[3:2]]} : 32'h00000000;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_data;
      s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule

/* File: sim/axt_aux_timers_assertions.sv */
`timescale 1ns/1ps
module axt_aux_timers_assertions
  import axt_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [NUM_TIMED-1:0] timed_input_in,
  input wire logic [NUM_BLOCKABLE-1:0] channel_block_input_in,
  input wire logic [NUM_PASS-1:0] passthrough_input_in,
  input wire logic prot_trip_out,
  input wire logic trip_pulse_out,
  input wire logic recorder_trigger_out,
  input wire logic trip_led_out,
  input wire logic trip_flag_out,
  input wire logic alarm_out,
  input wire logic alarm_led_out,
  input wire logic [NUM_TIMED-1:0] aux_state_out,
  input wire logic [NUM_TIMED-1:0] channel_delay_expired_out,
  input wire logic [NUM_PASS-1:0] passthrough_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0] age_reg;
  // pins need the synchronisers filled before levels may be compared
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  a_pulse_single: assert property (
    trip_pulse_out |=> !trip_pulse_out)
    else $error("trip pulse longer than one clock");
  a_pulse_on_rise: assert property (
    $rose(prot_trip_out) |-> ##[0:1] trip_pulse_out)
    else $error("trip rose without a pulse");
  a_recorder_pulse: assert property (
    trip_pulse_out |-> recorder_trigger_out)
    else $error("recorder not triggered with trip pulse");
  a_trip_led_flag: assert property (
    trip_led_out == prot_trip_out && trip_flag_out == prot_trip_out)
    else $error("trip led or flag disagrees with trip");
  a_alarm_led: assert property (
    alarm_led_out == alarm_out)
    else $error("alarm led disagrees with alarm");
  a_pass_level: assert property (
    (age_reg == 3'h7 && $stable(passthrough_input_in)) [*5]
    |-> passthrough_out == passthrough_input_in)
    else $error("passthrough output does not follow input");
  a_raw_state: assert property (
    (age_reg == 3'h7 && $stable(timed_input_in)) [*5]
    |-> aux_state_out == timed_input_in)
    else $error("raw state does not follow input");
  a_block_quiet: assert property (
    (age_reg == 3'h7 && channel_block_input_in == 3'h7) [*8]
    |-> channel_delay_expired_out[2:0] == 3'h0)
    else $error("blocked channel expired");
endmodule
bind axt_aux_timers axt_aux_timers_assertions chk_u (
  .clk_in, .nrst_in, .timed_input_in, .channel_block_input_in,
  .passthrough_input_in, .prot_trip_out, .trip_pulse_out,
  .recorder_trigger_out, .trip_led_out, .trip_flag_out, .alarm_out,
  .alarm_led_out, .aux_state_out, .channel_delay_expired_out,
  .passthrough_out
);

/* File: sim/axt_field_model.sv */
`timescale 1ns/1ps
module axt_field_model
  import axt_pkg::*;
(
  input wire logic clk_in,
  input wire logic trip_pulse_in,
  output logic [NUM_TIMED-1:0] timed_out,
  output logic [NUM_BLOCKABLE-1:0] block_out,
  output logic [NUM_PASS-1:0] pass_out,
  output logic inrush_out,
  output logic sig_reset_out
);
  int pulse_cnt = 0;
  initial begin
    timed_out = '0;
    block_out = '0;
    pass_out = '0;
    inrush_out = 1'b0;
    sig_reset_out = 1'b0;
  end
  // the trip coil sees every pulse, so a doubled or lost pulse shows here
  always @(posedge clk_in) begin
    if (trip_pulse_in) pulse_cnt <= pulse_cnt + 1;
  end
  task automatic drive(input logic [3:0] t, input logic [2:0] b,
                       input logic [1:0] p, input logic i, input logic s);
    timed_out <= t;
    block_out <= b;
    pass_out <= p;
    inrush_out <= i;
    sig_reset_out <= s;
  endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import axt_pkg::*;
  localparam int TD = 10;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r, pin, pout;
  logic [3:0] tin, aux_st, dexp;
  logic [2:0] blk;
  logic inr, srst, trip, tpls, rec, tled, tflag, alm, aled, bop, bcl, irq;
  logic [2:0] fns [7] = '{FN_ALARM, FN_TRIP_INRUSH, FN_TRIP_INRUSH,
    FN_LOAD_SHED, FN_RECLOSE_HIGH, FN_RECLOSE_LOW, FN_RECLOSE_LOW};
  logic [3:0] exs [7] = '{4'h4, 4'h0, 4'h8, 4'h2, 4'h1, 4'h1, 4'h0};
  logic [6:0] lvs = 7'h5f, inrs = 7'h02;
  int err_count = 0, n_compared = 0, n;
  always #2 clk_in = ~clk_in;
  axt_aux_timers #(.TICK_DIV(TD)) dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .timed_input_in(tin),
    .channel_block_input_in(blk), .passthrough_input_in(pin),
    .inrush_block_in(inr), .signal_reset_in(srst),
    .prot_trip_out(trip), .trip_pulse_out(tpls),
    .recorder_trigger_out(rec), .trip_led_out(tled),
    .trip_flag_out(tflag), .alarm_out(alm), .alarm_led_out(aled),
    .breaker_open_command_out(bop), .breaker_close_command_out(bcl),
    .aux_state_out(aux_st), .channel_delay_expired_out(dexp),
    .passthrough_out(pout), .irq_out(irq)
  );
  axt_field_model fm_u (
    .clk_in(clk_in), .trip_pulse_in(tpls), .timed_out(tin),
    .block_out(blk), .pass_out(pin), .inrush_out(inr),
    .sig_reset_out(srst)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    ta = 0;
    tw = 0;
    tb = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_in);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb) begin
      @(negedge clk_in);
      tb = bvalid;
      r = bresp;
      @(posedge clk_in);
    end
    bready <= 1'b0;
    // let an edge pass so a following call never reassigns in this step
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    bit t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge clk_in);
      t = arready;
      @(posedge clk_in);
    end
    arvalid <= 1'b0;
    t = 0;
    while (!t) begin
      @(negedge clk_in);
      t = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk_in);
    end
    rready <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  // other channels get the spare code so only one channel drives outputs
  task automatic sf(input int ch, input logic [2:0] code);
    logic [31:0] f;
    f = 32'h00000fff;
    f[3*ch +: 3] = code;
    wr(OFS_FUNC, f);
  endtask
  task automatic wait_exp(input int ch);
    n = 0;
    while (dexp[ch] !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // the whole sequence needs about a thousand cycles; allow ample margin
  initial begin
    #80000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    cyc(12);
    nrst_in <= 1'b1;
    cyc(2);
    chk({trip, alm, bop, bcl, irq}, 32'h0);
    rc(OFS_FUNC, 32'h0);
    rc(OFS_IRQ_MASK, 32'h0);
    rc(OFS_DELAY0, 32'h0);
    wr(OFS_DELAY1, 32'h000aae60);
    rc(OFS_DELAY1, {12'h000, DELAY_MAX_MS});
    rd(8'h40);
    chk(r, RESP_SLVERR);
    wr(8'h44, 32'h1);
    chk(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'hffff);
    chk(r, RESP_OKAY);
    for (int c = 0; c < NUM_TIMED; c++) wr(OFS_DELAY0 + 8'(4 * c), 32'h4);
    rc(OFS_DELAY2, 32'h4);
    sf(0, FN_TRIP);
    fm_u.drive(4'h1, 3'h0, 2'h0, 1'b0, 1'b0);
    wait_exp(0);
    chk(32'(n > 3 * TD && n < 4 * TD + 10), 32'h1);
    cyc(3);
    chk({trip, tled, tflag, alm, bop}, 32'h1c);
    chk(fm_u.pulse_cnt, 32'h1);
    rc(OFS_STATUS, 32'h11);
    chk(irq, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1f);
    cyc(3);
    chk(irq, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    cyc(3);
    chk(irq, 32'h0);
    fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
    cyc(4);
    chk({trip, dexp}, 32'h0);
    fm_u.drive(4'h1, 3'h0, 2'h0, 1'b0, 1'b0);
    cyc(2 * TD);
    fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
    cyc(2 * TD);
    fm_u.drive(4'h1, 3'h0, 2'h0, 1'b0, 1'b0);
    cyc(3 * TD);
    chk({trip, dexp}, 32'h0);
    sf(3, FN_TRIP);
    fm_u.drive(4'hf, 3'h7, 2'h0, 1'b0, 1'b0);
    cyc(6 * TD);
    chk({aux_st, dexp, trip}, 32'h1f1);
    fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
    for (int k = 0; k < 7; k++) begin
      sf(2, fns[k]);
      fm_u.drive({1'b0, lvs[k], 2'b0}, 3'h0, 2'h0, inrs[k], 1'b0);
      cyc(6 * TD);
      chk({trip, alm, bop, bcl}, exs[k]);
      sf(2, 3'h7);
      fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
      cyc(8);
    end
    sf(0, FN_TRIP_LATCH);
    for (int k = 0; k < 2; k++) begin
      fm_u.drive(4'h1, 3'h0, 2'h0, 1'b0, 1'b0);
      cyc(6 * TD);
      fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
      cyc(6);
      chk(trip, 32'h1);
      if (k == 0) fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b1);
      else wr(OFS_CTRL, 32'h1);
      cyc(6);
      chk(trip, 32'h0);
      fm_u.drive(4'h0, 3'h0, 2'h0, 1'b0, 1'b0);
      cyc(2);
    end
    fm_u.drive(4'h0, 3'h0, 2'h2, 1'b0, 1'b0);
    cyc(5);
    chk(pout, 32'h2);
    wr(OFS_DELAY3, 32'h0);
    sf(3, FN_ALARM);
    fm_u.drive(4'h8, 3'h0, 2'h0, 1'b0, 1'b0);
    wait_exp(3);
    chk(32'(n < 8), 32'h1);
    // a reset in mid-run must drop an expired channel at once
    cyc(1);
    nrst_in <= 1'b0;
    cyc(2);
    chk({alm, dexp, irq}, 32'h0);
    nrst_in <= 1'b1;
    cyc(2);
    rc(OFS_FUNC, 32'h0);
    tally_and_finish();
  end
endmodule
